// ---- prb_pkg.sv ----
// constants shared by the peripheral register window decode logic
package prb_pkg;

  // ----------------------------------------------------------------
  // window geometry
  // ----------------------------------------------------------------
  localparam int WINDOW_BYTES = 256;
  localparam int OFS_W = 8;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BASE_W = ADDR_W - OFS_W;
  localparam logic [BASE_W-1:0] BASE_MASK_IO = 12'hfff;
  localparam logic [BASE_W-1:0] BASE_MASK_MEM = 12'h0ff;

  // ----------------------------------------------------------------
  // register offsets inside the window
  // ----------------------------------------------------------------
  localparam logic [OFS_W-1:0] OFS_RELEASE_LEVEL = 8'hf4;
  localparam logic [OFS_W-1:0] OFS_STRAP_CAPTURE = 8'hf6;
  localparam logic [OFS_W-1:0] OFS_BLOCK_RELOC = 8'hfe;

  // ----------------------------------------------------------------
  // block relocation register layout
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RELOC_RESET = 16'h20ff;
  localparam logic [DATA_W-1:0] RELOC_WMASK = 16'h5fff;
  localparam int RELOC_SLAVE_BIT = 14;
  localparam int RELOC_SPACE_BIT = 12;
  localparam int RELOC_BASE_MSB = 11;
  localparam logic [DATA_W-1:0] LOW_BYTE_MASK = 16'h00ff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // release level register
  // ----------------------------------------------------------------
  localparam int REL_CODE_W = 8;
  localparam logic [7:0] REL_CODE_DEFAULT = 8'h5a; // arbitrary value
  localparam logic [7:0] REL_RESERVED_BITS = 8'h00;

endpackage

// ---- prb_strap_hold.sv ----
// strap capture register: follows the pins while reset is held, frozen after release
`timescale 1ns/1ps
module prb_strap_hold
  import prb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pin levels to be captured
  input wire logic [DATA_W-1:0] pin_levels,
  // captured value
  output logic [DATA_W-1:0] strap_value_bits_reg
);

  // the sample taken at the last clock edge while reset is high is the one held after its release
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_value_bits_reg <= pin_levels;
    end
  end

endmodule // prb_strap_hold

// ---- prb_window_decode.sv ----
// peripheral register window decode, relocation, strap capture and release level
`timescale 1ns/1ps
module prb_window_decode
  import prb_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0,
  parameter logic [REL_CODE_W-1:0] RELEASE_CODE = REL_CODE_DEFAULT // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // processor access request
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_mem,
  input wire logic acc_byte,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  // answer to the processor
  output logic window_hit_reg,
  output logic rd_valid_reg,
  output logic [DATA_W-1:0] rd_data_reg,
  // strap pins
  input wire logic [DATA_W-1:0] muxed_addr_data_bus,
  input wire logic [7:0] upper_addr_only_lines,
  // forwarded access to the peripherals that own the other registers
  output logic periph_wr_reg,
  output logic periph_rd_reg,
  output logic [OFS_W-1:0] periph_offset_reg,
  output logic [DATA_W-1:0] periph_wdata_reg,
  input wire logic [DATA_W-1:0] periph_rdata,
  // configuration outputs
  output logic irq_ctrl_slave_select_reg,
  output logic window_space_select_reg,
  output logic [BASE_W-1:0] window_base_bits_reg
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] block_relocation_reg;
  logic [DATA_W-1:0] block_relocation_next;
  logic [DATA_W-1:0] strap_value_bits;
  logic [DATA_W-1:0] strap_pins;
  logic [BASE_W-1:0] base_mask;
  logic [OFS_W-1:0] acc_offset;
  logic space_match;
  logic base_match;
  logic window_sel;
  logic full_write;
  logic own_reg;
  logic [DATA_W-1:0] rd_data_next;

  assign acc_offset = acc_addr[OFS_W-1:0];
  // memory mapping drops the four top base bits from the compare
  assign base_mask = block_relocation_reg[RELOC_SPACE_BIT] ? BASE_MASK_MEM : BASE_MASK_IO;
  assign base_match = ((acc_addr[ADDR_W-1:OFS_W] ^ block_relocation_reg[RELOC_BASE_MSB:0])
                       & base_mask) == '0;
  assign space_match = (acc_mem == block_relocation_reg[RELOC_SPACE_BIT]);
  assign window_sel = acc_valid && space_match && base_match;

  // the narrow bus assembles the word, so a byte write always moves 16 bits
  assign full_write = NARROW_BUS || !acc_byte;

  assign own_reg = (acc_offset == OFS_BLOCK_RELOC) || (acc_offset == OFS_STRAP_CAPTURE) ||
                   (acc_offset == OFS_RELEASE_LEVEL);

  // ----------------------------------------------------------------
  // block relocation register
  // ----------------------------------------------------------------
  always_comb begin
    block_relocation_next = block_relocation_reg;
    if (window_sel && acc_write && acc_offset == OFS_BLOCK_RELOC) begin
      if (full_write) begin
        block_relocation_next = (block_relocation_reg & ~RELOC_WMASK) | (acc_wdata & RELOC_WMASK);
      end else begin
        // wide bus byte write on the even lane touches the low byte only
        block_relocation_next = (block_relocation_reg & ~(RELOC_WMASK & LOW_BYTE_MASK)) |
                                (acc_wdata & RELOC_WMASK & LOW_BYTE_MASK);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      block_relocation_reg <= RELOC_RESET;
    end else begin
      block_relocation_reg <= block_relocation_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_ctrl_slave_select_reg <= RELOC_RESET[RELOC_SLAVE_BIT];
      window_space_select_reg <= RELOC_RESET[RELOC_SPACE_BIT];
      window_base_bits_reg <= RELOC_RESET[RELOC_BASE_MSB:0];
    end else begin
      irq_ctrl_slave_select_reg <= block_relocation_reg[RELOC_SLAVE_BIT];
      window_space_select_reg <= block_relocation_reg[RELOC_SPACE_BIT];
      window_base_bits_reg <= block_relocation_reg[RELOC_BASE_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // the narrow variant has no data on the upper lines, only address
  assign strap_pins = NARROW_BUS ? {upper_addr_only_lines, muxed_addr_data_bus[7:0]}
                                 : muxed_addr_data_bus;

  prb_strap_hold u_strap (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_levels(strap_pins),
    .strap_value_bits_reg(strap_value_bits)
  );

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  always_comb begin
    case (acc_offset)
      OFS_BLOCK_RELOC: rd_data_next = block_relocation_reg;
      OFS_STRAP_CAPTURE: rd_data_next = strap_value_bits;
      OFS_RELEASE_LEVEL: rd_data_next = {RELEASE_CODE, REL_RESERVED_BITS};
      default: rd_data_next = periph_rdata;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      window_hit_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= ZERO_WORD;
    end else begin
      window_hit_reg <= window_sel;
      rd_valid_reg <= window_sel && !acc_write;
      if (window_sel && !acc_write) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // forwarding to the owning peripherals
  // ----------------------------------------------------------------
  // writes to the read-only offsets are absorbed here and go nowhere
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_wr_reg <= 1'b0;
      periph_rd_reg <= 1'b0;
      periph_offset_reg <= '0;
      periph_wdata_reg <= ZERO_WORD;
    end else begin
      periph_wr_reg <= window_sel && acc_write && !own_reg;
      periph_rd_reg <= window_sel && !acc_write && !own_reg;
      if (window_sel) begin
        periph_offset_reg <= acc_offset;
        periph_wdata_reg <= full_write ? acc_wdata : (acc_wdata & LOW_BYTE_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic past_valid;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  reloc_reset_val_a: assert property (@(posedge clk_sys) $fell(reset) |->
    block_relocation_reg == RELOC_RESET)
    else $error("relocation register not at reset value after reset");

  slave_mode_out_a: assert property (window_sel && acc_write && acc_offset == OFS_BLOCK_RELOC && full_write
    |-> ##2 irq_ctrl_slave_select_reg == $past(acc_wdata[RELOC_SLAVE_BIT], 2))
    else $error("slave select output does not follow written bit");

  space_sel_out_a: assert property (window_sel && acc_write && acc_offset == OFS_BLOCK_RELOC && full_write
    |-> ##2 window_space_select_reg == $past(acc_wdata[RELOC_SPACE_BIT], 2))
    else $error("space select output does not follow written bit");

  space_miss_a: assert property (acc_valid && acc_mem != block_relocation_reg[RELOC_SPACE_BIT]
    |=> !window_hit_reg)
    else $error("access in wrong space selected the window");

  io_base_miss_a: assert property (acc_valid && !block_relocation_reg[RELOC_SPACE_BIT]
    && acc_addr[ADDR_W-1:OFS_W] != block_relocation_reg[RELOC_BASE_MSB:0] |=> !window_hit_reg)
    else $error("io access outside base selected the window");

  mem_top_ignore_a: assert property (acc_valid && acc_mem && block_relocation_reg[RELOC_SPACE_BIT]
    && acc_addr[15:OFS_W] == block_relocation_reg[7:0] |=> window_hit_reg)
    else $error("memory access ignoring top base bits missed");

  narrow_write_a: assert property (NARROW_BUS && window_sel && acc_write && acc_byte
    && acc_offset == OFS_BLOCK_RELOC |=> (block_relocation_reg & RELOC_WMASK)
    == ($past(acc_wdata) & RELOC_WMASK))
    else $error("narrow byte write did not move a full word");

  strap_frozen_a: assert property (past_valid && !reset |-> ##1 $stable(strap_value_bits))
    else $error("strap capture changed outside reset");

  strap_read_a: assert property (window_sel && !acc_write && acc_offset == OFS_STRAP_CAPTURE
    |=> rd_valid_reg && rd_data_reg == strap_value_bits)
    else $error("strap capture read returned wrong value");

  release_read_a: assert property (window_sel && !acc_write && acc_offset == OFS_RELEASE_LEVEL
    |=> rd_data_reg == {RELEASE_CODE, REL_RESERVED_BITS})
    else $error("release level read returned wrong value");

  ro_write_ignore_a: assert property (window_sel && acc_write && (acc_offset == OFS_STRAP_CAPTURE
    || acc_offset == OFS_RELEASE_LEVEL) |=> $stable(block_relocation_reg) && !periph_wr_reg)
    else $error("write to read-only register had an effect");

  offset_forward_a: assert property (window_sel && !own_reg
    |=> periph_offset_reg == $past(acc_offset) && (periph_wr_reg || periph_rd_reg))
    else $error("window access not forwarded to peripheral");

  reloc_write_c: cover property (window_sel && acc_write && acc_offset == OFS_BLOCK_RELOC);
  mem_space_hit_c: cover property (window_sel && acc_mem);
  release_read_c: cover property (window_sel && !acc_write && acc_offset == OFS_RELEASE_LEVEL);
  periph_read_c: cover property (window_sel && !acc_write && !own_reg ##1 rd_valid_reg);

endmodule // prb_window_decode

// ---- prb_core_model.sv ----
// processor core model issuing single-cycle register accesses
`timescale 1ns/1ps
module prb_core_model
  import prb_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // access request
  output logic acc_valid,
  output logic acc_write,
  output logic acc_mem,
  output logic acc_byte,
  output logic [ADDR_W-1:0] acc_addr,
  output logic [DATA_W-1:0] acc_wdata
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_mem = 1'b0;
    acc_byte = 1'b0;
    acc_addr = 20'h00000;
    acc_wdata = 16'h0000;
  end

  // one access per call; released lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic m, input logic b, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_mem <= m;
    acc_byte <= b & w;
    acc_addr <= {a[ADDR_W-1:1], 1'b0};
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_wdata <= ~d;
    #1;
  endtask
endmodule // prb_core_model

// ---- peripheral_block_relocation_bench.sv ----
// self-checking bench for the peripheral register window decode
`timescale 1ns/1ps
module peripheral_block_relocation_bench
  import prb_pkg::*;
;
  logic clk_sys, reset, acc_valid, acc_write, acc_mem, acc_byte;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, rd_data_reg, periph_wdata_reg, muxed_addr_data_bus;
  logic [7:0] upper_addr_only_lines, periph_offset_reg;
  logic window_hit_reg, rd_valid_reg, periph_wr_reg, periph_rd_reg;
  logic irq_ctrl_slave_select_reg, window_space_select_reg;
  logic [BASE_W-1:0] window_base_bits_reg;
  logic [DATA_W-1:0] periph_rdata;
  // second copy built for the narrow bus variant, watched on the lines that differ
  logic n_window_hit_reg, n_window_space_select_reg;
  logic [DATA_W-1:0] n_rd_data_reg, n_periph_wdata_reg;
  int n_errors = 0;
  int comparisons = 0;

  assign periph_rdata = {8'hc3, acc_addr[7:0]};

  prb_core_model core (.clk_sys(clk_sys), .acc_valid(acc_valid), .acc_write(acc_write), .acc_mem(acc_mem),
    .acc_byte(acc_byte), .acc_addr(acc_addr), .acc_wdata(acc_wdata));

  prb_window_decode uut (.clk_sys(clk_sys), .reset(reset), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_mem(acc_mem), .acc_byte(acc_byte), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .window_hit_reg(window_hit_reg), .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg),
    .muxed_addr_data_bus(muxed_addr_data_bus), .upper_addr_only_lines(upper_addr_only_lines),
    .periph_wr_reg(periph_wr_reg), .periph_rd_reg(periph_rd_reg), .periph_offset_reg(periph_offset_reg),
    .periph_wdata_reg(periph_wdata_reg), .periph_rdata(periph_rdata),
    .irq_ctrl_slave_select_reg(irq_ctrl_slave_select_reg), .window_space_select_reg(window_space_select_reg),
    .window_base_bits_reg(window_base_bits_reg));

  prb_window_decode #(.NARROW_BUS(1'b1)) uut_narrow (.clk_sys(clk_sys), .reset(reset), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_mem(acc_mem), .acc_byte(acc_byte), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .window_hit_reg(n_window_hit_reg), .rd_valid_reg(), .rd_data_reg(n_rd_data_reg),
    .muxed_addr_data_bus(muxed_addr_data_bus), .upper_addr_only_lines(upper_addr_only_lines),
    .periph_wr_reg(), .periph_rd_reg(), .periph_offset_reg(),
    .periph_wdata_reg(n_periph_wdata_reg), .periph_rdata(periph_rdata),
    .irq_ctrl_slave_select_reg(), .window_space_select_reg(n_window_space_select_reg),
    .window_base_bits_reg());

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic m, input logic [19:0] a, input logic [15:0] exp);
    core.xfer(1'b0, m, 1'b0, a, 16'h0000);
    chk({what, " hit"}, 16'h0001, {15'h0, window_hit_reg & rd_valid_reg});
    chk(what, exp, rd_data_reg);
  endtask

  task automatic cfg_chk(input logic s, input logic m, input logic [11:0] b);
    chk("slave", {15'h0, s}, {15'h0, irq_ctrl_slave_select_reg});
    chk("space", {15'h0, m}, {15'h0, window_space_select_reg});
    chk("base", {4'h0, b}, {4'h0, window_base_bits_reg});
  endtask

  // the default base 0ffh puts the window at 0ff00h in io space
  task automatic t_defaults;
    cfg_chk(1'b0, 1'b0, 12'h0ff);
    rd_chk("reloc", 1'b0, 20'h0fffe, 16'h20ff);
    rd_chk("release", 1'b0, 20'h0fff4, {REL_CODE_DEFAULT, 8'h00});
    rd_chk("strap", 1'b0, 20'h0fff6, 16'hbeef);
    chk("narrow strap", 16'h77ef, n_rd_data_reg);
    $display("test defaults done");
  endtask

  task automatic t_read_only;
    core.xfer(1'b1, 1'b0, 1'b0, 20'h0fff4, 16'hffff);
    chk("ro wr fwd", 16'h0000, {15'h0, periph_wr_reg});
    core.xfer(1'b1, 1'b0, 1'b0, 20'h0fff6, 16'h0000);
    chk("strap wr fwd", 16'h0000, {15'h0, periph_wr_reg});
    rd_chk("release kept", 1'b0, 20'h0fff4, {REL_CODE_DEFAULT, 8'h00});
    rd_chk("strap kept", 1'b0, 20'h0fff6, 16'hbeef);
    $display("test read_only done");
  endtask

  task automatic t_periph;
    rd_chk("periph rd", 1'b0, 20'h0ff30, 16'hc330);
    chk("prd pulse", 16'h0001, {15'h0, periph_rd_reg});
    chk("offset", 16'h0030, {8'h00, periph_offset_reg});
    rd_chk("offset 0", 1'b0, 20'h0ff00, 16'hc300);
    core.xfer(1'b1, 1'b0, 1'b1, 20'h0ff40, 16'h1234);
    chk("pwr pulse", 16'h0001, {15'h0, periph_wr_reg});
    chk("byte lane", 16'h0034, periph_wdata_reg);
    chk("narrow byte lane", 16'h1234, n_periph_wdata_reg);
    core.xfer(1'b0, 1'b0, 1'b0, 20'h0fe30, 16'h0000);
    chk("outside hit", 16'h0000, {15'h0, window_hit_reg});
    core.xfer(1'b0, 1'b1, 1'b0, 20'h0ff30, 16'h0000);
    chk("wrong space", 16'h0000, {15'h0, window_hit_reg});
    $display("test periph done");
  endtask

  task automatic t_relocate;
    core.xfer(1'b1, 1'b0, 1'b0, 20'h0fffe, 16'hffff);
    core.xfer(1'b0, 1'b0, 1'b0, 20'h0fffe, 16'h0000);
    chk("io miss", 16'h0000, {15'h0, window_hit_reg});
    cfg_chk(1'b1, 1'b1, 12'hfff);
    rd_chk("mem reloc", 1'b1, 20'h0fffe, 16'h7fff);
    core.xfer(1'b1, 1'b1, 1'b0, 20'h3fffe, 16'h00ff);
    core.xfer(1'b0, 1'b1, 1'b0, 20'h3fffe, 16'h0000);
    chk("mem miss", 16'h0000, {15'h0, window_hit_reg});
    cfg_chk(1'b0, 1'b0, 12'h0ff);
    rd_chk("io reloc", 1'b0, 20'h0fffe, 16'h20ff);
    // byte write: the wide copy takes only the low byte, the narrow copy the whole word
    core.xfer(1'b1, 1'b0, 1'b1, 20'h0fffe, 16'h10ff);
    rd_chk("wide byte reloc", 1'b0, 20'h0fffe, 16'h20ff);
    chk("narrow space", 16'h0001, {15'h0, n_window_space_select_reg});
    chk("narrow miss", 16'h0000, {15'h0, n_window_hit_reg});
    $display("test relocate done");
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the four tests need well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    muxed_addr_data_bus = 16'hbeef;
    upper_addr_only_lines = 8'h77;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    // pins move at release so a strap register that keeps sampling shows it
    muxed_addr_data_bus <= 16'h4110;
    upper_addr_only_lines <= 8'h88;
    t_defaults();
    t_read_only();
    t_periph();
    t_relocate();
    close_out();
  end
endmodule // peripheral_block_relocation_bench
